// >>> include/hsbc_pkg.sv
// Shared constants and state types for the hot-swap bus connect controller.
package hsbc_pkg;

  // Core clock rate.
  localparam int unsigned CORE_CLK_HZ   = 20_000_000;

  // Initialization time after power-up or enable, in microseconds.
  localparam int unsigned INIT_TIME_US  = 130;
  localparam int unsigned INIT_CYCLES   =
    (INIT_TIME_US * (CORE_CLK_HZ / 1_000_000) < 1) ? 1 :
    INIT_TIME_US * (CORE_CLK_HZ / 1_000_000);

  // Bus idle interval before a join, in microseconds.
  localparam int unsigned IDLE_TIME_US  = 120;
  localparam int unsigned IDLE_CYCLES   =
    (IDLE_TIME_US * (CORE_CLK_HZ / 1_000_000) < 1) ? 1 :
    IDLE_TIME_US * (CORE_CLK_HZ / 1_000_000);

  // Link cycles a released pair is left alone before it is judged again.
  localparam int unsigned SETTLE_CYCLES = 3;

  // Timer width used by the core controller.
  localparam int unsigned TMR_W         = 12;

  // Reset values of the driven pin controls.
  localparam logic        OE_N_RST      = 1'b1;
  localparam logic        PIN_OUT_RST   = 1'b0;

  typedef enum logic [1:0] {
    HSBC_OFF,
    HSBC_INIT,
    HSBC_ARMED,
    HSBC_JOINED
  } hsbc_state_e;

  typedef enum logic [1:0] {
    HSBC_PR_IDLE,
    HSBC_PR_DRV_A,
    HSBC_PR_DRV_B,
    HSBC_PR_SETTLE
  } hsbc_pair_e;

endpackage

// >>> testbench/hsbc_bus_model.sv
// Wired-AND bus segments with pull-ups on both sides of the buffer.
`timescale 1ns/1ps
module hsbc_bus_model (
  input  wire logic [3:0] ext_low,
  input  wire logic [3:0] dev_oe_n,
  input  wire logic [3:0] dev_out,
  output logic      [3:0] pin
);
  // A line nobody pulls floats up to the pull-up level, never a stale value.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin[i] = !(ext_low[i] || (!dev_oe_n[i] && !dev_out[i]));
    end
  end
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the hot-swap bus connect controller.
`timescale 1ns/1ps
module tb_top;
  import hsbc_pkg::*;
  localparam int unsigned INIT_N = 20;
  localparam int unsigned IDLE_N = 16;
  // Pin index 0 backplane data, 1 card data, 2 backplane clock, 3 card clock.
  logic       core_clk   = 1'b0;
  logic       link_clk   = 1'b0;
  logic       srst       = 1'b1;
  logic       enable_pin = 1'b0;
  logic [3:0] ext_low    = 4'h0;
  logic [1:0] boost_seen = 2'b00;
  logic       na_boost   = 1'b0;
  logic       ready_d    = 1'b0;
  logic       ready_q[$];
  wire  [3:0] pin;
  wire  [3:0] oe_n;
  wire  [3:0] out;
  wire        ready_out;
  wire        ready_oe_n;
  wire        bp_pc;
  wire        cd_pc;
  wire        d_bst;
  wire        c_bst;
  wire        low_power;
  wire        na_bp_pc;
  wire        na_cd_pc;
  wire        na_d_bst;
  wire        na_c_bst;
  wire  [6:0] obs = {low_power, bp_pc, ready_oe_n, oe_n};
  int         fails   = 0;
  int         checked = 0;
  int         seed    = 32'h6fc641d4;

  always #25 core_clk = !core_clk;
  // The link clock edges meet the core clock's edges only once every 200 ns.
  always #40 link_clk = !link_clk;

  hsbc_top #(.INIT_CYC(INIT_N), .IDLE_CYC(IDLE_N), .ACCEL(1'b1)) DUT (
    .core_clk                (core_clk),
    .srst                    (srst),
    .link_clk                (link_clk),
    .enable_pin              (enable_pin),
    .backplane_data_pin_in   (pin[0]),
    .backplane_data_pin_out  (out[0]),
    .backplane_data_pin_oe_n (oe_n[0]),
    .card_data_pin_in        (pin[1]),
    .card_data_pin_out       (out[1]),
    .card_data_pin_oe_n      (oe_n[1]),
    .backplane_clock_pin_in  (pin[2]),
    .backplane_clock_pin_out (out[2]),
    .backplane_clock_pin_oe_n(oe_n[2]),
    .card_clock_pin_in       (pin[3]),
    .card_clock_pin_out      (out[3]),
    .card_clock_pin_oe_n     (oe_n[3]),
    .ready_out               (ready_out),
    .ready_oe_n              (ready_oe_n),
    .backplane_precharge     (bp_pc),
    .card_precharge          (cd_pc),
    .data_boost              (d_bst),
    .clock_boost             (c_bst),
    .low_power               (low_power)
  );

  hsbc_bus_model bus (
    .ext_low (ext_low),
    .dev_oe_n(oe_n),
    .dev_out (out),
    .pin     (pin)
  );

  // A unit without accelerators only listens to the same bus.
  hsbc_top #(.INIT_CYC(INIT_N), .IDLE_CYC(IDLE_N), .ACCEL(1'b0))
  DUT_BASIC (
    .core_clk                (core_clk),
    .srst                    (srst),
    .link_clk                (link_clk),
    .enable_pin              (enable_pin),
    .backplane_data_pin_in   (pin[0]),
    .backplane_data_pin_out  (),
    .backplane_data_pin_oe_n (),
    .card_data_pin_in        (pin[1]),
    .card_data_pin_out       (),
    .card_data_pin_oe_n      (),
    .backplane_clock_pin_in  (pin[2]),
    .backplane_clock_pin_out (),
    .backplane_clock_pin_oe_n(),
    .card_clock_pin_in       (pin[3]),
    .card_clock_pin_out      (),
    .card_clock_pin_oe_n     (),
    .ready_out               (),
    .ready_oe_n              (),
    .backplane_precharge     (na_bp_pc),
    .card_precharge          (na_cd_pc),
    .data_boost              (na_d_bst),
    .clock_boost             (na_c_bst),
    .low_power               ()
  );

  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask

  task automatic wait_for(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (obs[s] !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    checked++;
    if (obs[s] !== v) begin
      fails++;
      $display("MISMATCH t=%0t output %0d timed out", $time, s);
      finish_test();
    end
  endtask

  always @(posedge link_clk) begin
    if (d_bst || c_bst) begin
      boost_seen <= boost_seen | {c_bst, d_bst};
    end
    if (na_d_bst || na_c_bst) begin
      na_boost <= 1'b1;
    end
  end

  // Every move of ready is matched against the oldest expected level.
  always @(negedge core_clk) begin
    if (!srst && ready_oe_n !== ready_d) begin
      if (ready_q.size() == 0) begin
        chk(1'b0, 1'b1, "unexpected ready move");
      end else begin
        chk(ready_oe_n, ready_q.pop_front(), "ready level");
        if (ready_oe_n === 1'b1) begin
          chk(bp_pc | cd_pc, 1'b0, "precharge at join");
        end
      end
    end
    ready_d <= ready_oe_n;
  end

  initial begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    srst = 1'b0;
    ext_low = 4'h5;
    repeat (30) @(negedge core_clk);
    chk(oe_n === 4'hf, 1'b1, "pins driven while off");
    chk(low_power, 1'b1, "low power while off");
    chk(bp_pc | cd_pc, 1'b0, "precharge while off");
    chk(ready_oe_n, 1'b0, "ready while off");
    chk(out === 4'h0 && ready_out === 1'b0, 1'b1, "open-drain level");
    ext_low = 4'h0;
    enable_pin = 1'b1;
    ready_q.push_back(1'b1);
    wait_for(5, 1'b1, 8);
    chk(cd_pc, 1'b1, "card precharge");
    chk(na_bp_pc, 1'b1, "basic unit backplane precharge");
    chk(na_cd_pc, 1'b0, "basic unit card precharge");
    chk(low_power, 1'b0, "low power when on");
    repeat (INIT_N + IDLE_N - 3) @(negedge core_clk);
    chk(ready_oe_n, 1'b0, "join too early");
    wait_for(4, 1'b1, 8);
    for (int i = 0; i < 4; i++) begin
      ext_low[i] = 1'b1;
      wait_for(i ^ 1, 1'b0, 12);
      repeat (2 + ($random(seed) & 7)) @(negedge core_clk);
      ext_low[i ^ 1] = 1'b1;
      ext_low[i] = 1'b0;
      wait_for(i, 1'b0, 30);
      repeat (1 + ($random(seed) & 7)) @(negedge core_clk);
      boost_seen = 2'b00;
      ext_low[i ^ 1] = 1'b0;
      wait_for(i, 1'b1, 30);
      repeat (16) @(negedge core_clk);
      chk(oe_n === 4'hf, 1'b1, "pair not released");
      chk(boost_seen === 2'(1 << (i >> 1)), 1'b1, "boost pair");
    end
    enable_pin = 1'b0;
    ready_q.push_back(1'b0);
    wait_for(4, 1'b0, 6);
    wait_for(6, 1'b1, 6);
    chk(bp_pc | cd_pc, 1'b0, "precharge after disable");
    ext_low = 4'h1;
    repeat (8) @(negedge core_clk);
    chk(oe_n === 4'hf, 1'b1, "mirroring while off");
    enable_pin = 1'b1;
    ready_q.push_back(1'b1);
    repeat (INIT_N + 8) @(negedge core_clk);
    chk(ready_oe_n, 1'b0, "join with a low pin");
    ext_low = 4'h0;
    wait_for(4, 1'b1, 8);
    enable_pin = 1'b0;
    ready_q.push_back(1'b0);
    wait_for(4, 1'b0, 6);
    repeat (4) @(negedge core_clk);
    chk(ready_q.size() == 0, 1'b1, "ready moves missing");
    chk(na_boost, 1'b0, "boost without accelerators");
    finish_test();
  end
endmodule

// >>> verilog/hsbc_pair.sv
// One joined line pair: mirrors lows between two open-drain pins.
`timescale 1ns/1ps
module hsbc_pair #(
  parameter int unsigned SETTLE = hsbc_pkg::SETTLE_CYCLES,
  parameter bit          ACCEL  = 1'b1
) (
  input  wire logic link_clk,
  input  wire logic rst,
  input  wire logic join_en,
  input  wire logic a_pin_in,
  input  wire logic b_pin_in,
  output logic      a_oe_n,
  output logic      b_oe_n,
  output logic      boost
);
  import hsbc_pkg::*;

  localparam int unsigned CW = $clog2(SETTLE + 1);

  initial begin
    if (SETTLE < 3) begin
      $error("SETTLE must cover the two-stage pin synchroniser");
    end
  end

  logic            a_m_r, a_s_r, b_m_r, b_s_r;
  hsbc_pair_e      st_r, st_nxt;
  logic [CW-1:0]   cnt_r, cnt_nxt;
  logic            a_oe_n_r, a_oe_n_nxt;
  logic            b_oe_n_r, b_oe_n_nxt;
  logic            boost_r, boost_nxt;

  // Pins are sampled on the link clock through two flops.
  always_ff @(posedge link_clk) begin // RULE16
    a_m_r <= a_pin_in;
    a_s_r <= a_m_r;
    b_m_r <= b_pin_in;
    b_s_r <= b_m_r;
  end

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    boost_nxt = 1'b0;
    if (!join_en) begin
      st_nxt  = HSBC_PR_IDLE; // RULE3
      cnt_nxt = '0;
    end else begin
      unique case (st_r)
        HSBC_PR_IDLE: begin
          if (!a_s_r) begin
            st_nxt = HSBC_PR_DRV_B; // RULE10
          end else if (!b_s_r) begin
            st_nxt = HSBC_PR_DRV_A; // RULE10
          end
        end
        HSBC_PR_DRV_A: begin
          if (b_s_r) begin
            st_nxt  = HSBC_PR_SETTLE;
            cnt_nxt = '0;
          end
        end
        HSBC_PR_DRV_B: begin
          if (a_s_r) begin
            st_nxt  = HSBC_PR_SETTLE;
            cnt_nxt = '0;
          end
        end
        HSBC_PR_SETTLE: begin
          // Our own low takes two flops to leave the sampled view, so the
          // pair is not judged until it has really had time to rise.
          if (cnt_r == CW'(SETTLE - 1)) begin
            if (a_s_r && b_s_r) begin
              st_nxt    = HSBC_PR_IDLE; // RULE12
              boost_nxt = ACCEL;        // RULE12
            end else if (!a_s_r) begin
              st_nxt = HSBC_PR_DRV_B;   // RULE11
            end else begin
              st_nxt = HSBC_PR_DRV_A;   // RULE11
            end
          end else begin
            cnt_nxt = cnt_r + CW'(1);
          end
        end
      endcase
    end
    a_oe_n_nxt = (st_nxt != HSBC_PR_DRV_A);
    b_oe_n_nxt = (st_nxt != HSBC_PR_DRV_B);
  end

  always_ff @(posedge link_clk) begin
    if (rst) begin
      st_r     <= HSBC_PR_IDLE;
      cnt_r    <= '0;
      a_oe_n_r <= OE_N_RST;
      b_oe_n_r <= OE_N_RST;
      boost_r  <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      a_oe_n_r <= a_oe_n_nxt;
      b_oe_n_r <= b_oe_n_nxt;
      boost_r  <= boost_nxt;
    end
  end

  assign a_oe_n = a_oe_n_r;
  assign b_oe_n = b_oe_n_r;
  assign boost  = boost_r;

  chk_mirror_low: assert property ( // RULE10
    @(posedge link_clk) disable iff (rst)
    join_en && st_r == HSBC_PR_IDLE && !a_s_r |=> !b_oe_n_r)
    else $error("low on side a not mirrored to side b");

  chk_hold_both: assert property ( // RULE11
    @(posedge link_clk) disable iff (rst)
    join_en && st_r == HSBC_PR_DRV_B && !a_s_r |=> !b_oe_n_r)
    else $error("pair released while side a still low");

  chk_isolate_off: assert property ( // RULE3
    @(posedge link_clk) disable iff (rst)
    !join_en |=> a_oe_n_r && b_oe_n_r && !boost_r)
    else $error("pair drives while not joined");

  chk_boost_rise: assert property ( // RULE12
    @(posedge link_clk) disable iff (rst)
    boost_r |-> $past(a_s_r) && $past(b_s_r) && a_oe_n_r && b_oe_n_r)
    else $error("boost without both lines released and high");

endmodule

// >>> verilog/hsbc_top.sv
// Hot-swap bus connect controller: start-up, join decision, pin drivers.
//
// Function
// (RULE1) Power-up keeps segments apart, pins undriven.
// (RULE2) Enable low holds disconnected low-power state.
// (RULE3) Enable low stops boost and isolates pairs.
// (RULE4) Power-up or enable rise starts initialization.
// (RULE5) Stop and idle detector armed after initialization.
// (RULE6) Join on idle interval or backplane stop.
// (RULE7) Precharge during start-up, off at join.
// (RULE8) Precharge backplane only, or all with accelerators.
// (RULE9) Ready pulls low until segments are joined.
// (RULE10) Joined: low on one pin drives other.
// (RULE11) Both low held until all drivers release; code releases both sides for SETTLE cycles once one side rises.
// (RULE12) Released pair rising drops pull-down, boosts.
// (RULE13) Enable low also disables the precharge.
// (RULE14) Ready high only when enabled and started.
// (RULE15) Initialization lasts about 130 microseconds.
// (RULE16) Pins sampled on clock; timers are counters.
// (RULE17) Stop is data rising while clock high.
`timescale 1ns/1ps
module hsbc_top #(
  parameter int unsigned INIT_CYC = hsbc_pkg::INIT_CYCLES,
  parameter int unsigned IDLE_CYC = hsbc_pkg::IDLE_CYCLES,
  parameter bit          ACCEL    = 1'b1
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic link_clk,
  input  wire logic enable_pin,
  input  wire logic backplane_data_pin_in,
  output logic      backplane_data_pin_out,
  output logic      backplane_data_pin_oe_n,
  input  wire logic card_data_pin_in,
  output logic      card_data_pin_out,
  output logic      card_data_pin_oe_n,
  input  wire logic backplane_clock_pin_in,
  output logic      backplane_clock_pin_out,
  output logic      backplane_clock_pin_oe_n,
  input  wire logic card_clock_pin_in,
  output logic      card_clock_pin_out,
  output logic      card_clock_pin_oe_n,
  output logic      ready_out,
  output logic      ready_oe_n,
  output logic      backplane_precharge,
  output logic      card_precharge,
  output logic      data_boost,
  output logic      clock_boost,
  output logic      low_power
);
  import hsbc_pkg::*;

  initial begin
    if (INIT_CYC < 1 || INIT_CYC > (2 ** TMR_W) - 1) begin
      $error("INIT_CYC does not fit the start-up timer");
    end
    if (IDLE_CYC < 1 || IDLE_CYC > (2 ** TMR_W) - 1) begin
      $error("IDLE_CYC does not fit the idle timer");
    end
  end

  // ---------------- Core domain ----------------

  logic             en_m_r, en_s_r;
  logic [3:0]       pin_m_r, pin_s_r;
  logic             bpd_prev_r;
  hsbc_state_e      st_r, st_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;
  logic             joined_r, joined_nxt;
  logic             ready_oe_n_r, ready_oe_n_nxt;
  logic             bp_pc_r, bp_pc_nxt;
  logic             cd_pc_r, cd_pc_nxt;
  logic             low_pwr_r, low_pwr_nxt;
  logic             all_high;
  logic             stop_seen;
  logic             ready_out_r;

  // Pin order in the sampled vector: backplane data, backplane clock,
  // card data, card clock.
  always_ff @(posedge core_clk) begin // RULE16
    en_m_r  <= enable_pin;
    en_s_r  <= en_m_r;
    pin_m_r <= {card_clock_pin_in, card_data_pin_in,
                backplane_clock_pin_in, backplane_data_pin_in};
    pin_s_r <= pin_m_r;
    bpd_prev_r <= pin_s_r[0];
    // The ready pin is open drain, so its data level never leaves low.
    ready_out_r <= PIN_OUT_RST;
  end

  assign all_high  = &pin_s_r;
  // A stop is the backplane data line rising while its clock stays high.
  assign stop_seen = !bpd_prev_r && pin_s_r[0] && pin_s_r[1]; // RULE17

  always_comb begin
    st_nxt  = st_r;
    tmr_nxt = tmr_r;
    if (!en_s_r) begin
      st_nxt  = HSBC_OFF; // RULE2
      tmr_nxt = '0;
    end else begin
      unique case (st_r)
        HSBC_OFF: begin
          st_nxt  = HSBC_INIT; // RULE4
          tmr_nxt = '0;
        end
        HSBC_INIT: begin
          if (tmr_r == TMR_W'(INIT_CYC - 1)) begin
            st_nxt  = HSBC_ARMED; // RULE5 RULE15
            tmr_nxt = '0;
          end else begin
            tmr_nxt = tmr_r + TMR_W'(1);
          end
        end
        HSBC_ARMED: begin
          // The idle timer restarts on any low, so a card still busy
          // with a transfer cannot be joined mid-frame.
          if (!all_high) begin
            tmr_nxt = '0;
          end else if (stop_seen ||
                       tmr_r == TMR_W'(IDLE_CYC - 1)) begin
            st_nxt  = HSBC_JOINED; // RULE6
            tmr_nxt = '0;
          end else begin
            tmr_nxt = tmr_r + TMR_W'(1);
          end
        end
        HSBC_JOINED: begin
          st_nxt = HSBC_JOINED;
        end
      endcase
    end
    joined_nxt     = (st_nxt == HSBC_JOINED);
    ready_oe_n_nxt = joined_nxt;                   // RULE9 RULE14
    bp_pc_nxt      = (st_nxt == HSBC_INIT) ||
                     (st_nxt == HSBC_ARMED);       // RULE7 RULE13
    cd_pc_nxt      = ACCEL && bp_pc_nxt;           // RULE8
    low_pwr_nxt    = !en_s_r;                      // RULE2
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r         <= HSBC_OFF; // RULE1
      tmr_r        <= '0;
      joined_r     <= 1'b0;
      ready_oe_n_r <= 1'b0;
      bp_pc_r      <= 1'b0;
      cd_pc_r      <= 1'b0;
      low_pwr_r    <= 1'b1;
    end else begin
      st_r         <= st_nxt;
      tmr_r        <= tmr_nxt;
      joined_r     <= joined_nxt;
      ready_oe_n_r <= ready_oe_n_nxt;
      bp_pc_r      <= bp_pc_nxt;
      cd_pc_r      <= cd_pc_nxt;
      low_pwr_r    <= low_pwr_nxt;
    end
  end

  // ---------------- Link domain ----------------

  logic       lrst_m_r, lrst_r;
  logic       join_m_r, join_s_r;
  logic [3:0] pin_out_r;
  logic       bpd_oe_n, cdd_oe_n, bpc_oe_n, cdc_oe_n;
  logic       d_boost, c_boost;

  // Reset and the join level reach the link clock through two flops each.
  always_ff @(posedge link_clk) begin
    lrst_m_r <= srst;
    lrst_r   <= lrst_m_r;
    join_m_r <= joined_r;
    join_s_r <= join_m_r;
  end

  // Open-drain pins only ever drive low.
  always_ff @(posedge link_clk) begin
    pin_out_r <= {4{PIN_OUT_RST}};
  end

  hsbc_pair #(
    .SETTLE (SETTLE_CYCLES),
    .ACCEL  (ACCEL)
  ) u_data (
    .link_clk (link_clk),
    .rst      (lrst_r),
    .join_en  (join_s_r),
    .a_pin_in (backplane_data_pin_in),
    .b_pin_in (card_data_pin_in),
    .a_oe_n   (bpd_oe_n),
    .b_oe_n   (cdd_oe_n),
    .boost    (d_boost)
  );

  hsbc_pair #(
    .SETTLE (SETTLE_CYCLES),
    .ACCEL  (ACCEL)
  ) u_clock (
    .link_clk (link_clk),
    .rst      (lrst_r),
    .join_en  (join_s_r),
    .a_pin_in (backplane_clock_pin_in),
    .b_pin_in (card_clock_pin_in),
    .a_oe_n   (bpc_oe_n),
    .b_oe_n   (cdc_oe_n),
    .boost    (c_boost)
  );

  assign backplane_data_pin_out   = pin_out_r[0];
  assign backplane_clock_pin_out  = pin_out_r[1];
  assign card_data_pin_out        = pin_out_r[2];
  assign card_clock_pin_out       = pin_out_r[3];
  assign backplane_data_pin_oe_n  = bpd_oe_n;
  assign card_data_pin_oe_n       = cdd_oe_n;
  assign backplane_clock_pin_oe_n = bpc_oe_n;
  assign card_clock_pin_oe_n      = cdc_oe_n;
  assign data_boost               = d_boost;
  assign clock_boost              = c_boost;
  assign ready_out                = ready_out_r;
  assign ready_oe_n               = ready_oe_n_r;
  assign backplane_precharge      = bp_pc_r;
  assign card_precharge           = cd_pc_r;
  assign low_power                = low_pwr_r;

  // ---------------- Checks ----------------

  chk_disable_off: assert property ( // RULE2
    @(posedge core_clk) disable iff (srst)
    !en_s_r |=> st_r == HSBC_OFF && !joined_r && low_pwr_r)
    else $error("enable low did not force the off state");

  chk_disable_pc: assert property ( // RULE13
    @(posedge core_clk) disable iff (srst)
    !en_s_r |=> !bp_pc_r && !cd_pc_r && !ready_oe_n_r)
    else $error("enable low left precharge or ready active");

  chk_enable_init: assert property ( // RULE4
    @(posedge core_clk) disable iff (srst)
    en_s_r && st_r == HSBC_OFF |=> st_r == HSBC_INIT && bp_pc_r)
    else $error("enable did not start initialization");

  chk_init_length: assert property ( // RULE15
    @(posedge core_clk) disable iff (srst)
    st_r == HSBC_INIT && tmr_r < TMR_W'(INIT_CYC - 1) &&
    en_s_r |=> st_r == HSBC_INIT)
    else $error("initialization ended early");

  chk_arm_after: assert property ( // RULE5
    @(posedge core_clk) disable iff (srst)
    $rose(joined_r) |-> $past(st_r) == HSBC_ARMED)
    else $error("join taken before detector was armed");

  chk_join_cause: assert property ( // RULE6
    @(posedge core_clk) disable iff (srst)
    $rose(joined_r) |-> $past(all_high) &&
      ($past(stop_seen) || $past(tmr_r) == TMR_W'(IDLE_CYC - 1)))
    else $error("join without idle interval or stop");

  chk_pc_at_join: assert property ( // RULE7
    @(posedge core_clk) disable iff (srst)
    joined_r |-> !bp_pc_r && !cd_pc_r)
    else $error("precharge still on while joined");

  chk_pc_variant: assert property ( // RULE8
    @(posedge core_clk) disable iff (srst)
    cd_pc_r |-> bp_pc_r && ACCEL)
    else $error("card precharge outside the accelerator variant");

  chk_ready_join: assert property ( // RULE9
    @(posedge core_clk) disable iff (srst)
    ready_oe_n_r == joined_r && (!ready_oe_n_r || $past(en_s_r)))
    else $error("ready does not follow the joined state");

endmodule
